/* File: sgm_mode_ctrl.v */
// Mode control and clock synthesis for sample-clock generator 2
`include "sgm_consts.vh"

module sgm_mode_ctrl (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Device pins, active low
  input wire reset_pin_n,
  input wire pwrdwn_pin_n,
  // Control register write and read port
  input wire reg_wr_en,
  input wire [`SGM_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wr_data,
  output wire [15:0] reg_rd_data,
  // Programmed sample rate from the rate register
  input wire [15:0] sample_rate_value,
  // Sync reference pin
  input wire sync_reference_in,
  // Clock outputs
  output wire conversion_clock_out,
  output wire bit_clock_out,
  // Status
  output wire video_lock_active,
  output wire pll_gain_select
);

  // ==========================================================
  // Declarations
  reg [15:0] mode_q; // Mode register
  reg [15:0] rd_data_q; // Registered read data
  reg [2:0] rstn_sync_q; // Reset pin synchroniser
  reg [2:0] pdn_sync_q; // Power-down pin synchroniser
  reg [2:0] sync_in_q; // Sync pin synchroniser
  reg rstn_st_q; // Filtered reset pin level
  reg pdn_st_q; // Filtered power-down pin level
  reg sync_st_q; // Filtered sync level
  reg [23:0] per_cnt_q; // Clocks since last sync edge
  reg [23:0] per_est_q; // Tracked sync period
  reg [23:0] per_est_d;
  reg [31:0] conv_inc_q; // Conversion pin phase step
  reg [31:0] bit_inc_q; // Bit pin phase step
  reg [31:0] conv_acc_q; // Conversion pin phase
  reg [31:0] bit_acc_q; // Bit pin phase
  reg [23:0] conv_act_hz; // Actual conversion rate
  reg [23:0] bit_hz; // Bit clock rate, zero when off
  reg [47:0] ratio_num;
  reg [23:0] ratio_den;
  reg [47:0] ratio_q;
  wire hold; // Register reset to 00FF and locked
  wire sync_edge; // Rising sync edge pulse
  wire ref_source_select;
  wire video_lock_select;
  wire bitclk_offset_enable;
  wire conv_eight_sevenths;
  wire conv_pin_times_select;
  wire [7:0] rate_modifier_field;
  wire video_mode;
  wire normal_lock;
  wire [31:0] meas_hz;
  wire [23:0] conv_pin_hz;
  wire [18:0] rate_x87;
  wire [15:0] bit_table_hz;
  wire bit_code_ok;
  wire [15:0] coded_conv_hz;
  wire coded_x87;
  wire coded_ok;
  wire [15:0] video_conv_hz;
  wire video_ok;

  // Phase step for a frequency in Hz at the system clock rate
  function [31:0] nco_inc;
    input [23:0] f_hz;
    reg [39:0] prod;
    begin
      prod = {16'h0000, f_hz} * {24'h000000, `SGM_NCO_K};
      nco_inc = prod[39:`SGM_NCO_SHIFT];
    end
  endfunction

  // ==========================================================
  // Field extraction
  assign ref_source_select = mode_q[`SGM_B_REF];
  assign video_lock_select = mode_q[`SGM_B_VID];
  assign pll_gain_select = mode_q[`SGM_B_PLLG];
  assign bitclk_offset_enable = mode_q[`SGM_B_P200];
  assign conv_eight_sevenths = mode_q[`SGM_B_X87];
  assign conv_pin_times_select = mode_q[`SGM_B_C128];
  assign rate_modifier_field = mode_q[7:0];
  // Video bit only counts with sync reference
  assign video_mode = ref_source_select & video_lock_select;
  assign normal_lock = ref_source_select & ~video_lock_select;
  assign video_lock_active = video_mode;
  assign reg_rd_data = rd_data_q;

  // ==========================================================
  // Pin synchronisers: a change counts once stages two and three agree
  always @(posedge clk) begin
    rstn_sync_q <= {rstn_sync_q[1:0], reset_pin_n};
    pdn_sync_q <= {pdn_sync_q[1:0], pwrdwn_pin_n};
    sync_in_q <= {sync_in_q[1:0], sync_reference_in};
    if (rst) begin
      rstn_st_q <= 1'b0;
      pdn_st_q <= 1'b0;
      sync_st_q <= 1'b0;
    end else begin
      // Filtered levels follow only agreeing stages
      if (rstn_sync_q[1] == rstn_sync_q[2]) begin
        rstn_st_q <= rstn_sync_q[2];
      end
      if (pdn_sync_q[1] == pdn_sync_q[2]) begin
        pdn_st_q <= pdn_sync_q[2];
      end
      if (sync_in_q[1] == sync_in_q[2]) begin
        sync_st_q <= sync_in_q[2];
      end
    end
  end

  assign hold = rst | ~rstn_st_q | ~pdn_st_q;
  assign sync_edge = ~sync_st_q & (sync_in_q[1] == sync_in_q[2]) &
                     sync_in_q[2];

  // ==========================================================
  // Mode register: loaded with 00FF and write-locked while held
  always @(posedge clk) begin
    if (hold) begin
      mode_q <= `SGM_MODE_RST;
    end else if (reg_wr_en && reg_addr == `SGM_ADDR_MODE) begin
      // Reserved bits stored as zero
      mode_q <= reg_wr_data & `SGM_MODE_WMASK;
    end
  end

  // Read data one cycle after the address; other addresses read zero
  always @(posedge clk) begin
    if (rst) begin
      rd_data_q <= 16'h0000;
    end else if (reg_addr == `SGM_ADDR_MODE) begin
      rd_data_q <= mode_q;
    end else begin
      rd_data_q <= 16'h0000;
    end
  end

  // ==========================================================
  // Sync period tracker
  always @* begin
    // Infinite gain jumps, finite gain moves a fraction
    if (pll_gain_select) begin
      per_est_d = per_cnt_q;
    end else if (per_cnt_q > per_est_q) begin
      per_est_d = per_est_q +
                  ((per_cnt_q - per_est_q) >> `SGM_GAIN_SHIFT);
    end else begin
      per_est_d = per_est_q -
                  ((per_est_q - per_cnt_q) >> `SGM_GAIN_SHIFT);
    end
  end

  always @(posedge clk) begin
    if (hold) begin
      per_cnt_q <= 24'h000001;
      per_est_q <= `SGM_PER_MAX;
    end else if (sync_edge) begin
      // Period ends on each rising sync edge
      per_cnt_q <= 24'h000001;
      if (per_est_d != 24'h000000) begin
        per_est_q <= per_est_d;
      end
    end else if (per_cnt_q != `SGM_PER_MAX) begin
      per_cnt_q <= per_cnt_q + 24'h000001;
    end
  end

  assign meas_hz = `SGM_CLK_HZ / {8'h00, per_est_q};
  assign rate_x87 = {sample_rate_value, 3'h0} / {15'h0000, `SGM_MUL_SEVEN};

  // ==========================================================
  // Rate selection
  always @* begin
    if (video_mode) begin
      // Video rate from base and divisor
      conv_act_hz = video_ok ? {8'h00, video_conv_hz} : 24'h000000;
    end else if (ref_source_select) begin
      // Rate follows the tracked sync period
      conv_act_hz = meas_hz[23:0];
    end else if (conv_eight_sevenths) begin
      conv_act_hz = {5'h00, rate_x87};
    end else begin
      // Programmed rate from the rate register
      conv_act_hz = {8'h00, sample_rate_value};
    end
    // Scale by actual over coded rate
    ratio_num = {32'h00000000, bit_table_hz} * {24'h000000, conv_act_hz} *
                {44'h00000000000,
                 coded_x87 ? `SGM_MUL_SEVEN : `SGM_MUL_EIGHT};
    ratio_den = {8'h00, coded_conv_hz} * {20'h00000, `SGM_MUL_EIGHT};
    ratio_q = ratio_num / {24'h000000, ratio_den};
    if (video_mode) begin
      // No bit clock in video lock
      bit_hz = 24'h000000;
    end else if (rate_modifier_field[`SGM_F_HI] == `SGM_CODE_ALL &&
                 rate_modifier_field[`SGM_F_LO] == `SGM_CODE_ALL) begin
      bit_hz = conv_act_hz << `SGM_TIMES128;
    end else if (bit_code_ok && coded_ok) begin
      // Offset added on the bit pin only
      bit_hz = ratio_q[23:0] +
               (bitclk_offset_enable ? `SGM_OFFSET_HZ : 24'h000000);
    end else begin
      // Reserved codes leave the bit pin idle
      bit_hz = 24'h000000;
    end
  end

  // Conversion pin at 1x or 128x
  assign conv_pin_hz = conv_pin_times_select ?
                       (conv_act_hz << `SGM_TIMES128) : conv_act_hz;

  // ==========================================================
  // Phase accumulators driving the clock pins
  always @(posedge clk) begin
    if (hold) begin
      conv_inc_q <= 32'h00000000;
      bit_inc_q <= 32'h00000000;
      conv_acc_q <= 32'h00000000;
      bit_acc_q <= 32'h00000000;
    end else begin
      conv_inc_q <= nco_inc(conv_pin_hz);
      bit_inc_q <= nco_inc(bit_hz);
      // In normal lock the sync edge realigns phase; no shifting
      if (normal_lock && sync_edge) begin
        conv_acc_q <= 32'h00000000;
      end else begin
        conv_acc_q <= conv_acc_q + conv_inc_q;
      end
      if (bit_hz == 24'h000000 || (normal_lock && sync_edge)) begin
        bit_acc_q <= 32'h00000000;
      end else begin
        bit_acc_q <= bit_acc_q + bit_inc_q;
      end
    end
  end

  assign conversion_clock_out = conv_acc_q[31];
  assign bit_clock_out = bit_acc_q[31];

  // ==========================================================
  // Rate table lookup
  sgm_rate_table u_table (
    .rate_modifier_field(rate_modifier_field),
    .bit_table_hz(bit_table_hz),
    .bit_code_ok(bit_code_ok),
    .coded_conv_hz(coded_conv_hz),
    .coded_x87(coded_x87),
    .coded_ok(coded_ok),
    .video_conv_hz(video_conv_hz),
    .video_ok(video_ok)
  );

endmodule // sgm_mode_ctrl

/* File: sgm_consts.vh */
// Constants for the sample-clock generator 2 mode control block
`ifndef SGM_CONSTS_VH
`define SGM_CONSTS_VH

// ==========================================================
// Register map
`define SGM_ADDR_W 5
`define SGM_ADDR_MODE 5'h13
`define SGM_MODE_RST 16'h00FF
`define SGM_MODE_WMASK 16'hFCFF

// ==========================================================
// Mode register field positions
`define SGM_B_REF 15
`define SGM_B_VID 14
`define SGM_B_PLLG 13
`define SGM_B_P200 12
`define SGM_B_X87 11
`define SGM_B_C128 10
`define SGM_F_HI 7:4
`define SGM_F_LO 3:0
`define SGM_F_BASE 6:4
`define SGM_B_STD 7

// ==========================================================
// Timing and arithmetic
`define SGM_CLK_HZ 32'h0EE6B280
`define SGM_NCO_K 16'h112E
`define SGM_NCO_SHIFT 8
`define SGM_TIMES128 7
`define SGM_PER_MAX 24'hFFFFFF
`define SGM_GAIN_SHIFT 2

// ==========================================================
// Rate codes and frequencies in Hz
`define SGM_CODE_ALL 4'hF
`define SGM_BIT_LAST 4'hB
`define SGM_BIT_STEP 16'h0960
`define SGM_OFFSET_HZ 24'h0000C8
`define SGM_HZ_7200 16'h1C20
`define SGM_HZ_8400 16'h20D0
`define SGM_HZ_9000 16'h2328
`define SGM_HZ_9600 16'h2580
`define SGM_HZ_11200 16'h2BC0
`define SGM_HZ_12000 16'h2EE0
`define SGM_HZ_12800 16'h3200
`define SGM_HZ_48000 16'hBB80
`define SGM_HZ_32000 16'h7D00
`define SGM_HZ_44100 16'hAC44
`define SGM_HZ_29400 16'h72D8
`define SGM_HZ_44056 16'hAC18
`define SGM_MUL_SEVEN 4'h7
`define SGM_MUL_EIGHT 4'h8

`endif

/* File: sgm_rate_table.v */
// Rate code lookup for the modifier field of clock generator 2
`include "sgm_consts.vh"

module sgm_rate_table (
  // Modifier field from the mode register
  input wire [7:0] rate_modifier_field,
  // Bit clock table rate and validity
  output reg [15:0] bit_table_hz,
  output reg bit_code_ok,
  // Coded conversion rate, its 8/7 flag and validity
  output reg [15:0] coded_conv_hz,
  output reg coded_x87,
  output reg coded_ok,
  // Video lock conversion rate and validity
  output reg [15:0] video_conv_hz,
  output reg video_ok
);

  wire [3:0] rate_modifier_low;
  wire [3:0] rate_modifier_high;
  wire [2:0] video_base_select;
  wire video_standard_select;
  reg [15:0] base_hz;
  reg base_ok;

  assign rate_modifier_low = rate_modifier_field[`SGM_F_LO];
  assign rate_modifier_high = rate_modifier_field[`SGM_F_HI];
  assign video_base_select = rate_modifier_field[`SGM_F_BASE];
  assign video_standard_select = rate_modifier_field[`SGM_B_STD];

  // ==========================================================
  // Table decode
  always @* begin
    bit_code_ok = (rate_modifier_low <= `SGM_BIT_LAST);
    bit_table_hz = `SGM_BIT_STEP * {12'h000, rate_modifier_low + 4'h1};
    coded_ok = 1'b1;
    coded_x87 = 1'b0;
    case (rate_modifier_high)
      4'h0: coded_conv_hz = `SGM_HZ_7200;
      4'h1: coded_conv_hz = `SGM_HZ_8400;
      4'h2: coded_conv_hz = `SGM_HZ_9000;
      4'h3: coded_conv_hz = `SGM_HZ_9600;
      4'h4: coded_conv_hz = `SGM_HZ_11200;
      4'h5: coded_conv_hz = `SGM_HZ_12000;
      4'h6: coded_conv_hz = `SGM_HZ_12800;
      4'h7: begin
        coded_conv_hz = `SGM_HZ_7200;
        coded_x87 = 1'b1;
      end
      4'h8: begin
        coded_conv_hz = `SGM_HZ_9000;
        coded_x87 = 1'b1;
      end
      4'h9: begin
        coded_conv_hz = `SGM_HZ_9600;
        coded_x87 = 1'b1;
      end
      4'hA: begin
        coded_conv_hz = `SGM_HZ_12000;
        coded_x87 = 1'b1;
      end
      default: begin
        coded_conv_hz = `SGM_HZ_7200;
        coded_ok = 1'b0;
      end
    endcase
    // Video base per standard; PAL has four bases
    base_ok = 1'b1;
    case (video_base_select)
      3'h0: base_hz = `SGM_HZ_48000;
      3'h1: base_hz = `SGM_HZ_32000;
      3'h2: base_hz = `SGM_HZ_44100;
      3'h3: base_hz = `SGM_HZ_29400;
      3'h4: begin
        base_hz = `SGM_HZ_48000;
        base_ok = ~video_standard_select;
      end
      3'h5: begin
        base_hz = `SGM_HZ_44056;
        base_ok = ~video_standard_select;
      end
      default: begin
        base_hz = `SGM_HZ_48000;
        base_ok = 1'b0;
      end
    endcase
    // Base divided by divisor code plus one
    video_ok = base_ok & ~rate_modifier_low[3];
    // Four-bit sum so that divisor code 0111 gives 8, not a wrap to 0
    video_conv_hz = base_hz /
                    {12'h000, {1'b0, rate_modifier_low[2:0]} + 4'h1};
  end

endmodule // sgm_rate_table

/* File: sgm_host_model.sv */
// Host-side model that issues mode register writes
`include "sgm_consts.vh"
module sgm_host_model (
  // Clock
  input wire clk,
  // Requests from the bench
  input wire req,
  input wire [4:0] req_addr,
  input wire [15:0] req_data,
  // Register write port toward the block
  output logic reg_wr_en,
  output logic [4:0] reg_addr,
  output logic [15:0] reg_wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle values before the first request
  initial begin
    reg_wr_en = 1'b0;
    reg_addr = `SGM_ADDR_MODE;
    reg_wr_data = 16'h0000;
  end
  // Launch one write pulse per request
  always @(posedge clk) begin
    reg_wr_en <= req;
    reg_addr <= req_addr;
    // video bit only with sync reference, reserved bits zero
    reg_wr_data <= {req_data[15], req_data[14] & req_data[15],
                    req_data[13:10], 2'b00, req_data[7:0]};
  end
endmodule // sgm_host_model

/* File: sgm_mode_ctrl_chk.sv */
// Assertion checker for the generator 2 mode control ports
`include "sgm_consts.vh"
module sgm_mode_ctrl_chk (
  // Clock and reset
  input wire clk,
  input wire rst,
  // Device pins
  input wire reset_pin_n,
  input wire pwrdwn_pin_n,
  // Register port
  input wire reg_wr_en,
  input wire [`SGM_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wr_data,
  input wire [15:0] reg_rd_data,
  // Rate and sync inputs
  input wire [15:0] sample_rate_value,
  input wire sync_reference_in,
  // Outputs
  input wire conversion_clock_out,
  input wire bit_clock_out,
  input wire video_lock_active,
  input wire pll_gain_select
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Write steps
  sequence s_wr;
    (reset_pin_n && pwrdwn_pin_n)[*5] ##1
      (reg_wr_en && reg_addr == `SGM_ADDR_MODE);
  endsequence
  sequence s_rd;
    s_wr ##1 (reg_addr == `SGM_ADDR_MODE && !reg_wr_en);
  endsequence
  sequence s_calm;
    reg_addr == `SGM_ADDR_MODE ##1
      ($stable(pll_gain_select) && $stable(video_lock_active));
  endsequence
  // ==========================================================
  // Properties
  chk_wr_readback: assert property (
    s_rd |=> reg_rd_data == ($past(reg_wr_data, 2) & `SGM_MODE_WMASK))
    else $error("mode readback wrong");
  chk_resv_zero: assert property (reg_rd_data[9:8] == 2'b00)
    else $error("reserved bits read nonzero");
  chk_unmapped_zero: assert property (
    $past(reg_addr) != `SGM_ADDR_MODE |-> reg_rd_data == 16'h0000)
    else $error("unmapped read nonzero");
  chk_gain_level: assert property (
    s_calm |-> pll_gain_select == reg_rd_data[13])
    else $error("gain level mismatch");
  chk_video_level: assert property (
    s_calm |-> video_lock_active == (&reg_rd_data[15:14]))
    else $error("video level mismatch");
  chk_video_nobit: assert property (
    video_lock_active[*2] |-> !bit_clock_out)
    else $error("bit clock in video lock");
  chk_pin_default: assert property (
    (!reset_pin_n)[*6] ##1 reg_addr == `SGM_ADDR_MODE
      |=> reg_rd_data == `SGM_MODE_RST)
    else $error("mode not default under reset pin");
  chk_pwrdwn_quiet: assert property (
    (!pwrdwn_pin_n)[*6] |-> !conversion_clock_out && !bit_clock_out)
    else $error("clocks run in power down");
  chk_rst_release: assert property (
    $fell(rst) |-> reg_rd_data == 16'h0000 && !bit_clock_out
      && !conversion_clock_out)
    else $error("outputs not cleared by reset");
endmodule // sgm_mode_ctrl_chk

bind sgm_mode_ctrl sgm_mode_ctrl_chk i_chk (.clk(clk), .rst(rst),
  .reset_pin_n(reset_pin_n), .pwrdwn_pin_n(pwrdwn_pin_n),
  .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
  .reg_rd_data(reg_rd_data), .sample_rate_value(sample_rate_value),
  .sync_reference_in(sync_reference_in),
  .conversion_clock_out(conversion_clock_out),
  .bit_clock_out(bit_clock_out), .video_lock_active(video_lock_active),
  .pll_gain_select(pll_gain_select));

/* File: sample_clock_gen_mode_ctrl_bench.sv */
// Self-checking bench for the generator 2 mode control block
`include "sgm_consts.vh"
module sample_clock_gen_mode_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic pwrdwn_pin_n = 1'b1;
  logic req = 1'b0;
  logic [4:0] req_addr = `SGM_ADDR_MODE;
  logic [15:0] req_data = 16'h0000;
  logic [15:0] sample_rate_value = 16'hBB80;
  logic sync_reference_in = 1'b0;
  logic rd_req = 1'b0;
  wire reg_wr_en;
  wire [4:0] reg_addr;
  wire [15:0] reg_wr_data;
  wire [15:0] reg_rd_data;
  wire conversion_clock_out, bit_clock_out;
  wire video_lock_active, pll_gain_select;
  integer n_fail = 0;
  integer total_checks = 0;
  integer seed = 32'h378735aa;
  integer sync_cnt = 0;
  integer i;
  logic [15:0] d;
  logic [15:0] exp_q[$];
  // Video codes and their conversion rates
  // legal video pairs
  logic [7:0] vcode[6] = '{8'h80, 8'h91, 8'hA0, 8'h50, 8'h43, 8'h87};
  longint vhz[6] = '{48000, 16000, 44100, 44056, 12000, 6000};
  // ==========================================================
  // Clock and sync source, sync about 48 kHz
  always #2 clk = ~clk;
  always @(posedge clk) begin
    sync_cnt <= (sync_cnt == 5207) ? 0 : sync_cnt + 1;
    sync_reference_in <= (sync_cnt < 8);
  end
  sgm_host_model i_host (.clk(clk), .req(req), .req_addr(req_addr),
    .req_data(req_data), .reg_wr_en(reg_wr_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data));
  sgm_mode_ctrl i_dut (.clk(clk), .rst(rst), .reset_pin_n(reset_pin_n),
    .pwrdwn_pin_n(pwrdwn_pin_n), .reg_wr_en(reg_wr_en),
    .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
    .reg_rd_data(reg_rd_data), .sample_rate_value(sample_rate_value),
    .sync_reference_in(sync_reference_in),
    .conversion_clock_out(conversion_clock_out),
    .bit_clock_out(bit_clock_out), .video_lock_active(video_lock_active),
    .pll_gain_select(pll_gain_select));
  // ==========================================================
  // Checking
  task cmp16(input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %0t read %h expected %h", $time, g, e);
    end
  endtask
  task cmp_cnt(input longint e, input longint g);
    total_checks++;
    if (g < e - 3 || g > e + 3) begin
      n_fail++;
      $display("CHECK FAILED %0t edges %0d expected %0d", $time, g, e);
    end
  endtask
  // Readback monitor takes the oldest note
  always @(posedge clk) begin
    if (rd_req) cmp16(exp_q.pop_front(), reg_rd_data);
  end
  // Note an expected readback
  task rd(input logic [15:0] e);
    exp_q.push_back(e);
    rd_req <= 1'b1;
    @(posedge clk);
    rd_req <= 1'b0;
  endtask
  // One write then its readback
  task wr(input logic [4:0] a, input logic [15:0] v, input logic [15:0] e);
    req_addr <= a;
    req_data <= v;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (2) @(posedge clk);
    rd(e);
  endtask
  // Count rising edges on both pins against expected rates
  task meas(input longint fc, input longint fb, input int w);
    int nc, nb;
    logic pc, pb;
    nc = 0;
    nb = 0;
    pc = conversion_clock_out;
    pb = bit_clock_out;
    repeat (w) begin
      @(posedge clk);
      if (conversion_clock_out === 1'b1 && pc === 1'b0) nc++;
      if (bit_clock_out === 1'b1 && pb === 1'b0) nb++;
      pc = conversion_clock_out;
      pb = bit_clock_out;
    end
    cmp_cnt(fc * w / 250000000, nc);
    cmp_cnt(fb * w / 250000000, nb);
  endtask
  // Verdict
  task complete_run;
    if (n_fail == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #380000;
    n_fail++;
    complete_run;
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    rd(`SGM_MODE_RST);
    for (i = 0; i < 6; i++) begin
      d = $random(seed);
      wr(5'h13, d, {d[15], d[14] & d[15], d[13:10], 2'b00, d[7:0]});
    end
    wr(5'h05, 16'h1234, 16'h0000);
    wr(5'h13, 16'h04FF, 16'h04FF);
    meas(6144000, 6144000, 4000);
    wr(5'h13, 16'h0CFF, 16'h0CFF);
    meas(7021714, 7021714, 4000);
    sample_rate_value <= 16'hD2F0;
    wr(5'h13, 16'h000B, 16'h000B);
    meas(54000, 216000, 20000);
    wr(5'h13, 16'h000C, 16'h000C);
    meas(54000, 0, 4000);
    sample_rate_value <= 16'h2EE0;
    wr(5'h13, 16'h045B, 16'h045B);
    meas(1536000, 28800, 10000);
    sample_rate_value <= 16'hBB80;
    for (i = 0; i < 6; i++) begin
      wr(5'h13, {8'hC4, vcode[i]}, {8'hC4, vcode[i]});
      meas(vhz[i] * 128, 0, 4000);
    end
    wr(5'h13, 16'hA4FF, 16'hA4FF);
    repeat (15624) @(posedge clk);
    meas(6144393, 6144393, 4000);
    reset_pin_n <= 1'b0;
    pwrdwn_pin_n <= 1'b0;
    repeat (7) @(posedge clk);
    wr(5'h13, 16'h1111, `SGM_MODE_RST);
    reset_pin_n <= 1'b1;
    pwrdwn_pin_n <= 1'b1;
    repeat (5) @(posedge clk);
    rd(`SGM_MODE_RST);
    complete_run;
  end
endmodule // sample_clock_gen_mode_ctrl_bench
